// [rtl/icdac_defs.vh]
/*
 * Constants for the two-wire current converter write port: bus address,
 * register field positions, frame counts and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ICDAC_DEFS_VH
`define ICDAC_DEFS_VH

`define ICDAC_ADDR_HI        5'h03
`define ICDAC_ADDR_HI_MSB    7
`define ICDAC_ADDR_HI_LSB    3
`define ICDAC_RW_BIT         0
`define ICDAC_REG_W          16
`define ICDAC_PD_BIT         15
`define ICDAC_CODE_MSB       13
`define ICDAC_CODE_LSB       4
`define ICDAC_CODE_W         10
`define ICDAC_REG_RESET      16'h0000
`define ICDAC_CODE_RESET     10'h000
`define ICDAC_BITS_PER_BYTE  4'h8
`define ICDAC_LAST_BIT       4'h7
`define ICDAC_CNT_ZERO       4'h0
`define ICDAC_DATA_BYTES     2'h2
`define ICDAC_BYTE_ZERO      2'h0
`define ICDAC_BYTE_ONE       2'h1

`endif

// [rtl/icdac_sync.v]
/*
 * Two-flop synchroniser bank for the pins that arrive from outside
 * the reference clock domain.
 * Assumes an active-low asynchronous reset already released cleanly.
 */
`default_nettype none

module icdac_sync #(
    parameter W    = 3,
    parameter INIT = 3'h7
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Pins
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule

`default_nettype wire

// [rtl/icdac_port.v]
/*
 * Two-wire serial slave front end of a 10-bit current-sink converter.
 * Decodes start and stop, matches the address, acknowledges each received byte,
 * shifts two data bytes into the input register, copies it to the
 * converter register, returns it on a read and then clears it.
 * Assumes the bus clock is much slower than ref_clk (40 MHz) so that
 * every line change is seen after the two-flop synchroniser.
 */
// How it works
// - Upper five address bits must match; two low bits are ignored.
// - Eighth bit after address picks direction: zero write, one read.
// - Acknowledge driven low during clock low, held through ninth pulse.
// - Data changes only while clock low; high-phase changes are start/stop.
// - Every received byte, including second data byte, is acknowledged.
// - Each write and read carries exactly two data bytes.
// - Write data enters input register high byte first, MSB first.
// - After both data bytes, input register copies to converter register.
// - Input register top bit set requests power-down.
// - Bits 13 to 4 hold the 10-bit code; bits 14 and 3 to 0 ignored.
// - Read returns the register as two bytes in write order.
// - A completed read clears the whole input register.
// - Power-down pin forces power-down asynchronously.
`default_nettype none
`include "icdac_defs.vh"

module icdac_port (
    // Clock and reset
    input  wire                     ref_clk,
    input  wire                     arst_n,
    // Two-wire bus pins
    input  wire                     scl_in,
    input  wire                     sda_in,
    output wire                     sda_out,
    output wire                     sda_oe,
    // Power-down pin
    input  wire                     power_down_pin,
    // Converter side
    output reg  [`ICDAC_CODE_W-1:0] dac_code,
    output reg                      power_down_control,
    output wire                     power_down
);

    localparam ST_IDLE  = 6'h01;
    localparam ST_ADDR  = 6'h02;
    localparam ST_AACK  = 6'h04;
    localparam ST_WR    = 6'h08;
    localparam ST_RD    = 6'h10;
    localparam ST_MACK  = 6'h20;

    reg        rst_m_r;
    reg        rst_n_r;
    wire       rst_n;
    wire [1:0] pins_s;
    wire       scl_s;
    wire       sda_s;
    reg        scl_d_r;
    reg        sda_d_r;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;

    reg  [5:0]  state_r;
    reg  [3:0]  bit_cnt_r;
    reg  [1:0]  byte_cnt_r;
    reg  [7:0]  shift_r;
    reg  [`ICDAC_REG_W-1:0] dac_code_shift_register_r;
    reg         rw_r;
    reg         sda_low_r;
    reg         acked_r;

    // Reset is released through two flops; assertion stays asynchronous
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end
    assign rst_n = rst_n_r;

    // The power-down pin bypasses the synchroniser: it must act with no clock
    icdac_sync #(
        .W    (2),
        .INIT (2'h3)
    ) u_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     ({scl_in, sda_in}),
        .q     (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    // Data moving while clock is high is framing, never data
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Pin overrides register at once, without any clock
    assign power_down = power_down_pin | power_down_control;

    function addr_match;
        input [7:0] a;
        begin
            addr_match = (a[`ICDAC_ADDR_HI_MSB:`ICDAC_ADDR_HI_LSB] == `ICDAC_ADDR_HI);
        end
    endfunction

    function [7:0] rd_byte;
        input [`ICDAC_REG_W-1:0] r;
        input [1:0]              idx;
        begin
            if (idx == `ICDAC_BYTE_ZERO) begin
                rd_byte = r[15:8];
            end else begin
                rd_byte = r[7:0];
            end
        end
    endfunction

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r                   <= ST_IDLE;
            bit_cnt_r                 <= `ICDAC_CNT_ZERO;
            byte_cnt_r                <= `ICDAC_BYTE_ZERO;
            shift_r                   <= 8'h00;
            dac_code_shift_register_r <= `ICDAC_REG_RESET;
            rw_r                      <= 1'b0;
            sda_low_r                 <= 1'b0;
            acked_r                   <= 1'b0;
            dac_code                  <= `ICDAC_CODE_RESET;
            power_down_control        <= 1'b0;
        end else if (start_det) begin
            state_r    <= ST_ADDR;
            bit_cnt_r  <= `ICDAC_CNT_ZERO;
            byte_cnt_r <= `ICDAC_BYTE_ZERO;
            sda_low_r  <= 1'b0;
        end else if (stop_det) begin
            state_r   <= ST_IDLE;
            sda_low_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    sda_low_r <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == `ICDAC_BITS_PER_BYTE) begin
                        bit_cnt_r <= `ICDAC_CNT_ZERO;
                        if (addr_match(shift_r)) begin
                            rw_r      <= shift_r[`ICDAC_RW_BIT];
                            sda_low_r <= 1'b1;
                            state_r   <= ST_AACK;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    // Ack released on the falling edge that ends the ninth pulse
                    if (scl_fall) begin
                        acked_r <= 1'b0;
                        if (byte_cnt_r == `ICDAC_DATA_BYTES) begin
                            sda_low_r <= 1'b0;
                            state_r   <= ST_IDLE;
                        end else if (rw_r) begin
                            // First read bit is the top bit of the high byte
                            sda_low_r <= ~dac_code_shift_register_r[`ICDAC_PD_BIT];
                            shift_r   <= rd_byte(dac_code_shift_register_r, byte_cnt_r);
                            state_r   <= ST_RD;
                        end else begin
                            sda_low_r <= 1'b0;
                            state_r   <= ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        dac_code_shift_register_r <= {dac_code_shift_register_r[14:0],
                                                      sda_s};
                    end else if (scl_fall && bit_cnt_r == `ICDAC_BITS_PER_BYTE) begin
                        bit_cnt_r  <= `ICDAC_CNT_ZERO;
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                        sda_low_r  <= 1'b1;
                        state_r    <= ST_AACK;
                        if (byte_cnt_r == `ICDAC_BYTE_ONE) begin
                            dac_code <= dac_code_shift_register_r[`ICDAC_CODE_MSB:
                                                                  `ICDAC_CODE_LSB];
                            power_down_control <=
                                dac_code_shift_register_r[`ICDAC_PD_BIT];
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == `ICDAC_BITS_PER_BYTE) begin
                            bit_cnt_r <= `ICDAC_CNT_ZERO;
                            sda_low_r <= 1'b0;
                            state_r   <= ST_MACK;
                        end else begin
                            shift_r   <= {shift_r[6:0], 1'b0};
                            sda_low_r <= ~shift_r[6];
                        end
                    end
                end
                ST_MACK: begin
                    // Master acknowledge slot: sample, then next byte or finish
                    if (scl_rise) begin
                        acked_r <= ~sda_s;
                    end else if (scl_fall) begin
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                        if (byte_cnt_r == `ICDAC_BYTE_ONE) begin
                            dac_code_shift_register_r <= `ICDAC_REG_RESET;
                            state_r <= ST_IDLE;
                        end else begin
                            shift_r   <= rd_byte(dac_code_shift_register_r, `ICDAC_BYTE_ONE);
                            sda_low_r <= ~dac_code_shift_register_r[7];
                            state_r   <= ST_RD;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_low_r;

endmodule

`default_nettype wire

// [testbench/icdac_port_checker.sv]
/* Pin checker for the converter port.
   Assumes it is bound to icdac_port and sees only its ports. */
`default_nettype none
module icdac_port_checker (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       arst_n,
    // Bus pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // Converter side
    input wire logic       power_down_pin,
    input wire logic [9:0] dac_code,
    input wire logic       power_down_control,
    input wire logic       power_down
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_od; sda_oe |-> !sda_out; endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_pd; power_down == (power_down_pin | power_down_control); endproperty
    a_pd: assert property (p_pd) else $error("power-down output wrong");
    property p_pdc; $changed(power_down_control) |-> !$past(scl_in); endproperty
    a_pdc: assert property (p_pdc) else $error("soft power-down moved in high");
    property p_code; $changed(dac_code) |-> !$past(scl_in); endproperty
    a_code: assert property (p_code) else $error("code moved in clock high");
    property p_oe_low; $changed(sda_oe) |-> !$past(scl_in); endproperty
    a_oe_low: assert property (p_oe_low) else $error("data moved in clock high");
    property p_oe_hi; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
    a_oe_hi: assert property (p_oe_hi) else $error("data unstable in high");
    property p_ack_rise; $rose(sda_oe) |-> !scl_in; endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("pull not in low phase");
    property p_hold; $rose(sda_oe) |=> sda_oe [*4]; endproperty
    a_hold: assert property (p_hold) else $error("pull too short");
endmodule

bind icdac_port icdac_port_checker u_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .power_down_pin(power_down_pin),
    .dac_code(dac_code), .power_down_control(power_down_control),
    .power_down(power_down));
`default_nettype wire

// [testbench/icdac_bus_master.sv]
/* Bus master model: start, nine-bit slots, stop.
   Assumes a pull-up on the data line, resolved by the bench. */
`default_nettype none
module icdac_bus_master (
    // Bus
    output var logic scl,
    output var logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task start;
        sda_low = 1'b1;
        #100 scl = 1'b0;
    endtask
    // Data moves late in the low phase so a slow device release never looks like a stop
    task slot(input logic [8:0] v, output logic [8:0] s);
        for (int i = 8; i >= 0; i--) begin
            #105 sda_low = !v[i];
            #30 scl = 1'b1;
            #30 s[i] = sda;
            #35 scl = 1'b0;
        end
    endtask
    task stop;
        #105 sda_low = 1'b1;
        #30 scl = 1'b1;
        #100 sda_low = 1'b0;
        #100;
    endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
/* Bench for the converter port: table of writes, foreign address,
   read-back, clear on read and the power-down pin.
   Assumes icdac_bus_master as the far side. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [6:0] a; logic [15:0] d; logic [9:0] c; logic p;} icdac_row_t;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic pd_pin = 1'b0;
    logic scl, m_low, sda_oe, sda_out, pdc, pd;
    logic [9:0] code;
    logic [15:0] q;
    logic [2:0] k;
    int n_errors = 0;
    int checked = 0;
    // Open-drain data line with a pull-up
    wire logic sda = !(m_low | (sda_oe & !sda_out));
    icdac_row_t rows[4] = '{
        '{7'h0C, 16'h3FF0, 10'h3FF, 1'b0},
        '{7'h0D, 16'h8010, 10'h001, 1'b1},
        '{7'h0E, 16'hE00F, 10'h200, 1'b1},
        '{7'h0F, 16'h4A5F, 10'h0A5, 1'b0}};
    always #12.5 ref_clk = !ref_clk;
    icdac_port dut (.ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .power_down_pin(pd_pin),
        .dac_code(code), .power_down_control(pdc), .power_down(pd));
    icdac_bus_master m (.scl(scl), .sda_low(m_low), .sda(sda));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Master acks the first read byte and leaves the last one unacknowledged
    task xfer(input logic [6:0] a, input logic rw, input logic [15:0] d);
        logic [8:0] s;
        m.start();
        m.slot({a, rw, 1'b1}, s);
        k[2] = s[0];
        m.slot(rw ? 9'h1FE : {d[15:8], 1'b1}, s);
        k[1] = s[0];
        q[15:8] = s[8:1];
        m.slot(rw ? 9'h1FF : {d[7:0], 1'b1}, s);
        k[0] = s[0];
        q[7:0] = s[8:1];
        m.stop();
    endtask
    task tally_and_finish;
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'b0, rows[i].d);
            chk("write acks", 16'h0, {13'h0, k});
            chk("code", {6'h0, rows[i].c}, {6'h0, code});
            chk("soft power-down", {15'h0, rows[i].p}, {15'h0, pdc});
            chk("power-down out", {15'h0, rows[i].p}, {15'h0, pd});
        end
        xfer(7'h10, 1'b0, 16'h8123);
        chk("foreign ack", 16'h1, {15'h0, k[2]});
        chk("code kept", {6'h0, rows[3].c}, {6'h0, code});
        xfer(7'h0F, 1'b1, 16'h0);
        chk("read addr ack", 16'h0, {15'h0, k[2]});
        chk("read word", rows[3].d, q);
        xfer(7'h0C, 1'b1, 16'h0);
        chk("read after read", 16'h0, q);
        @(negedge ref_clk);
        pd_pin = 1'b1;
        #1;
        chk("pin power-down", 16'h1, {15'h0, pd});
        @(negedge ref_clk);
        pd_pin = 1'b0;
        #1;
        chk("pin released", 16'h0, {15'h0, pd});
        tally_and_finish();
    end
endmodule
`default_nettype wire
